// File: pkg/iak_pkg.sv
// Package: offsets, field layouts, reset values and counts for the acknowledge/handshake block
//
// Overview of operation
// - Transmit, check on: high acknowledge sets status
// - Transmit, check on: low acknowledge clears status
// - Writing check enable zero clears status
// - Receive: drive acknowledge slot with programmed bit
// - Read gives captured when transmitting, else programmed
// - Any acknowledge write updates receive acknowledge level
// - Reserved control positions read zero, write zero
// - Serial rate from extension plus clock selects
// - Access enable zero blocks interface register access
// - Handshake off: receive continuously while nothing pending
// - Handshake on: hold SCL low after frame
// - Reading receive data releases SCL, next frame
// - Acknowledge, extension, access, handshake reset zero
// - Pending set on buffer load, cleared by read
package iak_pkg;

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] IAK_OFS_CONTROL   = 8'h00;
	localparam logic [7:0] IAK_OFS_STATUS    = 8'h04;
	localparam logic [7:0] IAK_OFS_DATA      = 8'h08;
	localparam logic [7:0] IAK_OFS_MODE      = 8'h0C;
	localparam logic [7:0] IAK_OFS_SADDR     = 8'h10;
	localparam logic [7:0] IAK_OFS_SADDR2    = 8'h14;
	localparam logic [7:0] IAK_OFS_SICTL     = 8'h18;
	localparam logic [7:0] IAK_OFS_IRQ_STAT  = 8'h1C;
	localparam logic [7:0] IAK_OFS_IRQ_EN    = 8'h20;
	localparam logic [7:0] IAK_OFS_IRQ_CLR   = 8'h24;

	// ==========================================================
	// Field positions
	localparam int IAK_CTL_XMIT     = 4;
	localparam int IAK_CTL_ACKCHK   = 0;
	localparam int IAK_STS_ACK      = 0;
	localparam int IAK_MODE_CKS_LO  = 0;
	localparam int IAK_MODE_CKS_HI  = 2;
	localparam int IAK_SIC_RATEX    = 5;
	localparam int IAK_SIC_ACCESS   = 4;
	localparam int IAK_SIC_HANDS    = 3;
	localparam int IAK_SIC_PEND     = 1;
	localparam int IAK_SIC_STOPM    = 0;
	localparam int IAK_IRQ_NACK     = 0;
	localparam int IAK_IRQ_RXBYTE   = 1;
	localparam int IAK_IRQ_HOLD     = 2;
	localparam int IAK_IRQ_BITS     = 3;

	// Writable bits of the interrupt-control register; bit 1 is the read-only pending flag, the rest reserved
	localparam logic [7:0] IAK_SIC_WMASK = 8'h39;

	// ==========================================================
	// Reset values
	localparam logic [7:0] IAK_RST_BYTE = 8'h00;
	localparam logic       IAK_RST_BIT  = 1'b0;
	localparam logic [2:0] IAK_RST_IRQ  = 3'h0;

	// ==========================================================
	// Serial rate: base divisor, doubled by the extension bit
	localparam int IAK_RATE_BASE  = 8;
	localparam int IAK_RATE_WIDTH = 16;

	// Receive path states, Gray along run -> hold -> run
	typedef enum logic [1:0] {
		IAK_RX_RUN  = 2'b00,
		IAK_RX_HOLD = 2'b01
	} iak_rx_state_t;

endpackage

// File: hw/iak_rate_gen.sv
// Serial clock rate generator driven by extension and clock-select bits
`timescale 1ns/1ns
`default_nettype none
module iak_rate_gen import iak_pkg::*; #(
	parameter int BASE  = IAK_RATE_BASE,
	parameter int WIDTH = IAK_RATE_WIDTH
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       pce,
	input  wire logic       rate_extension_select,
	input  wire logic [2:0] clock_select,
	output var  logic       rate_tick
);

	// ==========================================================
	// Divisor selection
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	wire  [WIDTH-1:0] base_div = WIDTH'(BASE);
	wire  [WIDTH-1:0] sel_div  = base_div << clock_select;
	wire  [WIDTH-1:0] divisor  = rate_extension_select ? (sel_div << 1) : sel_div;
	wire              wrap     = (count >= divisor - WIDTH'(1));

	assign next_count = wrap ? '0 : count + WIDTH'(1);

	// ==========================================================
	// Counter and tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count     <= '0;
			rate_tick <= 1'b0;
		end else if (pce) begin
			count     <= next_count;
			rate_tick <= wrap;
		end
	end

endmodule
`default_nettype wire

// File: hw/iak_ctrl.sv
// Acknowledge handling and receive handshake control with APB registers
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module iak_ctrl import iak_pkg::*; #(
	parameter int RATE_BASE = IAK_RATE_BASE
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sda_in,
	input  wire logic        tx_ack_slot,
	input  wire logic        rx_frame_done,
	input  wire logic [7:0]  rx_shift_byte,
	output logic             ack_drive_level,
	output logic             scl_out,
	output logic             scl_oe,
	output logic             transmit_select,
	output logic             ack_check_enable,
	output logic             receive_data_pending,
	output logic [7:0]       tx_data,
	output logic             tx_data_written,
	output logic             rate_tick,
	output logic             irq
);

	// ==========================================================
	// Pin synchroniser for SDA
	logic sda_meta;
	logic sda_sync;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
		end else if (pce) begin
			sda_meta <= sda_in;
			sda_sync <= sda_meta;
		end
	end

	// ==========================================================
	// Register storage
	logic [7:0] control_reg;
	logic [7:0] status_hi;
	logic [7:0] mode_reg;
	logic [7:0] saddr_reg;
	logic [7:0] saddr2_reg;
	logic [7:0] sictl_reg;
	logic       ack_captured;
	logic       ack_programmed;
	logic [7:0] rx_buffer;
	logic [7:0] rx_held;
	logic       rx_held_valid;
	logic       pending;
	logic [IAK_IRQ_BITS-1:0] irq_status;
	logic [IAK_IRQ_BITS-1:0] irq_enable;
	iak_rx_state_t rx_state;
	iak_rx_state_t next_rx_state;

	// ==========================================================
	// APB decode
	function automatic logic is_gated(input logic [7:0] a);
		is_gated = (a == IAK_OFS_CONTROL) || (a == IAK_OFS_STATUS) ||
			(a == IAK_OFS_DATA) || (a == IAK_OFS_MODE) ||
			(a == IAK_OFS_SADDR) || (a == IAK_OFS_SADDR2);
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = is_gated(a) || (a == IAK_OFS_SICTL) || (a == IAK_OFS_IRQ_STAT) ||
			(a == IAK_OFS_IRQ_EN) || (a == IAK_OFS_IRQ_CLR);
	endfunction

	wire access_on  = sictl_reg[IAK_SIC_ACCESS];
	wire acc_phase  = psel && penable && !pready;
	wire blocked    = is_gated(paddr) && !access_on;
	wire bad_access = !is_mapped(paddr) || blocked;
	wire commit     = psel && penable && pready;
	wire ok_commit  = commit && !pslverr;
	wire lane0      = pstrb[0];
	wire wr_ok      = ok_commit && pwrite && lane0;
	wire rd_ok      = ok_commit && !pwrite;

	wire wr_control = wr_ok && (paddr == IAK_OFS_CONTROL);
	wire wr_status  = wr_ok && (paddr == IAK_OFS_STATUS);
	wire wr_data    = wr_ok && (paddr == IAK_OFS_DATA);
	wire wr_mode    = wr_ok && (paddr == IAK_OFS_MODE);
	wire wr_saddr   = wr_ok && (paddr == IAK_OFS_SADDR);
	wire wr_saddr2  = wr_ok && (paddr == IAK_OFS_SADDR2);
	wire wr_sictl   = wr_ok && (paddr == IAK_OFS_SICTL);
	wire wr_irq_en  = wr_ok && (paddr == IAK_OFS_IRQ_EN);
	wire wr_irq_clr = wr_ok && (paddr == IAK_OFS_IRQ_CLR);
	wire rd_data    = rd_ok && (paddr == IAK_OFS_DATA);

	// ==========================================================
	// Acknowledge path
	wire xmit_now       = control_reg[IAK_CTL_XMIT];
	wire ackchk_now     = control_reg[IAK_CTL_ACKCHK];
	wire ackchk_cleared = wr_control && !pwdata[IAK_CTL_ACKCHK];
	// Sampled level lags the pin by two cycles; core strobes late enough
	wire ack_event      = tx_ack_slot && xmit_now && ackchk_now;
	wire ack_view       = xmit_now ? ack_captured : ack_programmed;
	wire nack_event     = ack_event && sda_sync;

	logic next_ack_captured;
	always_comb begin
		next_ack_captured = ack_captured;
		if (ackchk_cleared)
			next_ack_captured = 1'b0;
		if (ack_event)
			next_ack_captured = sda_sync;
	end

	// ==========================================================
	// Receive path and handshake hold
	wire handshake  = sictl_reg[IAK_SIC_HANDS];
	// A read in the same cycle frees the buffer, so the byte is not stranded
	wire rx_to_buf  = rx_frame_done && (!pending || (rd_data && !rx_held_valid));
	wire rx_to_held = rx_frame_done && !rx_to_buf;
	wire held_move  = rd_data && rx_held_valid;
	wire release_rd = rd_data;

	logic next_pending;
	always_comb begin
		next_pending = pending;
		if (rd_data)
			next_pending = 1'b0;
		if (rx_to_buf || held_move)
			next_pending = 1'b1;
	end

	// Stall when software asked for it or a byte waits in the shift stage
	always_comb begin
		next_rx_state = rx_state;
		case (rx_state)
			IAK_RX_RUN: begin
				if (rx_frame_done && (handshake || rx_to_held))
					next_rx_state = IAK_RX_HOLD;
			end
			IAK_RX_HOLD: begin
				if (release_rd)
					next_rx_state = IAK_RX_RUN;
			end
			default: begin
				next_rx_state = IAK_RX_RUN;
			end
		endcase
	end

	wire hold_scl = (next_rx_state == IAK_RX_HOLD);

	// ==========================================================
	// Interrupt events, set wins over clear
	logic [IAK_IRQ_BITS-1:0] irq_events;
	logic [IAK_IRQ_BITS-1:0] next_irq_status;

	assign irq_events[IAK_IRQ_NACK]   = nack_event;
	assign irq_events[IAK_IRQ_RXBYTE] = rx_frame_done;
	assign irq_events[IAK_IRQ_HOLD]   = hold_scl && (rx_state == IAK_RX_RUN);

	genvar gi;
	generate
		for (gi = 0; gi < IAK_IRQ_BITS; gi++) begin : g_irq
			assign next_irq_status[gi] = irq_events[gi] ||
				(irq_status[gi] && !(wr_irq_clr && pwdata[gi]));
		end
	endgenerate

	// ==========================================================
	// Read data selection
	wire [7:0] status_view = {status_hi[7:1], ack_view};
	wire [7:0] sictl_view  = (sictl_reg & IAK_SIC_WMASK) |
		{6'h00, pending, 1'b0};
	logic [7:0] read_byte;

	always_comb begin
		read_byte = 8'h00;
		if (bad_access)
			read_byte = 8'h00;
		else if (paddr == IAK_OFS_CONTROL)
			read_byte = control_reg;
		else if (paddr == IAK_OFS_STATUS)
			read_byte = status_view;
		else if (paddr == IAK_OFS_DATA)
			read_byte = rx_buffer;
		else if (paddr == IAK_OFS_MODE)
			read_byte = mode_reg;
		else if (paddr == IAK_OFS_SADDR)
			read_byte = saddr_reg;
		else if (paddr == IAK_OFS_SADDR2)
			read_byte = saddr2_reg;
		else if (paddr == IAK_OFS_SICTL)
			read_byte = sictl_view;
		else if (paddr == IAK_OFS_IRQ_STAT)
			read_byte = {5'h00, irq_status};
		else if (paddr == IAK_OFS_IRQ_EN)
			read_byte = {5'h00, irq_enable};
		else
			read_byte = 8'h00;
	end

	// ==========================================================
	// APB handshake: answer one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (pce) begin
			pready  <= acc_phase;
			pslverr <= acc_phase && bad_access;
			if (acc_phase)
				prdata <= {24'h00_0000, pwrite ? 8'h00 : read_byte};
		end
	end

	// ==========================================================
	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg <= IAK_RST_BYTE;
			status_hi   <= IAK_RST_BYTE;
			mode_reg    <= IAK_RST_BYTE;
			saddr_reg   <= IAK_RST_BYTE;
			saddr2_reg  <= IAK_RST_BYTE;
			sictl_reg   <= IAK_RST_BYTE;
			irq_enable  <= IAK_RST_IRQ;
		end else if (pce) begin
			if (wr_control)
				control_reg <= pwdata[7:0];
			if (wr_status)
				status_hi <= pwdata[7:0];
			if (wr_mode)
				mode_reg <= pwdata[7:0];
			if (wr_saddr)
				saddr_reg <= pwdata[7:0];
			if (wr_saddr2)
				saddr2_reg <= pwdata[7:0];
			if (wr_sictl)
				sictl_reg <= pwdata[7:0] & IAK_SIC_WMASK;
			if (wr_irq_en)
				irq_enable <= pwdata[IAK_IRQ_BITS-1:0];
		end
	end

	// ==========================================================
	// Acknowledge state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_captured   <= IAK_RST_BIT;
			ack_programmed <= IAK_RST_BIT;
		end else if (pce) begin
			ack_captured <= next_ack_captured;
			if (wr_status)
				ack_programmed <= pwdata[IAK_STS_ACK];
		end
	end

	// ==========================================================
	// Receive buffer, shift-stage holding byte and stall state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buffer     <= IAK_RST_BYTE;
			rx_held       <= IAK_RST_BYTE;
			rx_held_valid <= IAK_RST_BIT;
			pending       <= IAK_RST_BIT;
			rx_state      <= IAK_RX_RUN;
		end else if (pce) begin
			if (rx_to_buf)
				rx_buffer <= rx_shift_byte;
			else if (held_move)
				rx_buffer <= rx_held;
			if (rx_to_held) begin
				rx_held       <= rx_shift_byte;
				rx_held_valid <= 1'b1;
			end else if (held_move)
				rx_held_valid <= 1'b0;
			pending  <= next_pending;
			rx_state <= next_rx_state;
		end
	end

	// ==========================================================
	// Interrupt status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= IAK_RST_IRQ;
			irq        <= 1'b0;
		end else if (pce) begin
			irq_status <= next_irq_status;
			irq        <= |(next_irq_status & irq_enable);
		end
	end

	// ==========================================================
	// Outputs towards the serial core and bus pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_drive_level      <= 1'b0;
			scl_out              <= 1'b0;
			scl_oe               <= 1'b0;
			transmit_select      <= 1'b0;
			ack_check_enable     <= 1'b0;
			receive_data_pending <= 1'b0;
			tx_data              <= IAK_RST_BYTE;
			tx_data_written      <= 1'b0;
		end else if (pce) begin
			ack_drive_level      <= wr_status ? pwdata[IAK_STS_ACK] : ack_programmed;
			scl_out              <= 1'b0;
			scl_oe               <= hold_scl;
			transmit_select      <= wr_control ? pwdata[IAK_CTL_XMIT] : xmit_now;
			ack_check_enable     <= wr_control ? pwdata[IAK_CTL_ACKCHK] : ackchk_now;
			receive_data_pending <= next_pending;
			tx_data_written      <= wr_data;
			if (wr_data)
				tx_data <= pwdata[7:0];
		end
	end

	// ==========================================================
	// Master-mode serial rate
	iak_rate_gen #(
		.BASE  (RATE_BASE),
		.WIDTH (IAK_RATE_WIDTH)
	) u_rate (
		.pclk                  (pclk),
		.presetn               (presetn),
		.pce                   (pce),
		.rate_extension_select (sictl_reg[IAK_SIC_RATEX]),
		.clock_select          (mode_reg[IAK_MODE_CKS_HI:IAK_MODE_CKS_LO]),
		.rate_tick             (rate_tick)
	);

endmodule
`default_nettype wire

// File: test/iak_ctrl_sva.sv
// Port checker for the acknowledge and handshake block
`timescale 1ns/1ns
`default_nettype none
module iak_ctrl_sva import iak_pkg::*; #(
	parameter int RATE_BASE = IAK_RATE_BASE
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        pce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rx_frame_done,
	input wire logic        ack_drive_level,
	input wire logic        scl_oe,
	input wire logic        ack_check_enable,
	input wire logic        receive_data_pending,
	input wire logic        rate_tick,
	input wire logic        irq
);
	wire logic  fin    = pce && psel && penable && pready && !pslverr;
	wire logic  wr_ok  = fin && pwrite && pstrb[0];
	wire logic  rd_dat = fin && !pwrite && paddr == IAK_OFS_DATA;
	logic [15:0] since;
	// Saturates so a long gap never wraps into a false short one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			since <= 16'hFFFF;
		else if (pce && rate_tick)
			since <= 16'h0000;
		else if (pce && since != 16'hFFFF)
			since <= since + 16'h0001;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// Properties
	property p_wait; pce && psel && penable && !pready |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("access not answered");
	property p_rst; $rose(presetn) |-> !scl_oe && !ack_drive_level && !irq; endproperty
	a_rst: assert property (p_rst) else $error("outputs not clear after reset");
	property p_ackchk; wr_ok && paddr == IAK_OFS_CONTROL
		|=> ack_check_enable == $past(pwdata[IAK_CTL_ACKCHK]); endproperty
	a_ackchk: assert property (p_ackchk) else $error("check enable not written");
	property p_ackw; wr_ok && paddr == IAK_OFS_STATUS
		|=> ack_drive_level == $past(pwdata[IAK_STS_ACK]); endproperty
	a_ackw: assert property (p_ackw) else $error("ack level not updated");
	property p_rsv; fin && !pwrite && paddr == IAK_OFS_SICTL
		|-> prdata[7:6] == 2'b00 && !prdata[2] && prdata[31:8] == 24'h000000; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
	property p_pend; pce && rx_frame_done && !receive_data_pending && !rd_dat
		|=> receive_data_pending; endproperty
	a_pend: assert property (p_pend) else $error("pending not set");
	property p_hold; pce && rx_frame_done && receive_data_pending && !rd_dat
		|=> scl_oe; endproperty
	a_hold: assert property (p_hold) else $error("clock not held");
	property p_rel; $fell(scl_oe) |-> $past(rd_dat) || $past(rd_dat, 2); endproperty
	a_rel: assert property (p_rel) else $error("clock released without read");
	property p_rate; rate_tick |-> since >= RATE_BASE - 1; endproperty
	a_rate: assert property (p_rate) else $error("rate tick too early");
endmodule
bind iak_ctrl iak_ctrl_sva #(.RATE_BASE(RATE_BASE)) chk_u (
	.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rx_frame_done(rx_frame_done), .ack_drive_level(ack_drive_level),
	.scl_oe(scl_oe), .ack_check_enable(ack_check_enable),
	.receive_data_pending(receive_data_pending), .rate_tick(rate_tick), .irq(irq)
);
`default_nettype wire

// File: test/iak_far_model.sv
// Far-side serial core and bus party model
`timescale 1ns/1ns
`default_nettype none
module iak_far_model (
	input  wire logic       pclk,
	input  wire logic       scl_oe,
	output var  logic       sda_in,
	output var  logic       tx_ack_slot,
	output var  logic       rx_frame_done,
	output var  logic [7:0] rx_shift_byte
);
	initial begin
		sda_in = 1'b1;
		tx_ack_slot = 1'b0;
		rx_frame_done = 1'b0;
		rx_shift_byte = 8'h00;
	end
	// SDA settles well ahead of the sample point
	task automatic ack_slot(input logic lvl);
		@(posedge pclk);
		sda_in <= lvl;
		repeat (4) @(posedge pclk);
		tx_ack_slot <= 1'b1;
		@(posedge pclk);
		tx_ack_slot <= 1'b0;
		sda_in <= 1'b1; // Released line rises on its pull-up
	endtask
	// A held clock stalls the sender, with a bounded wait
	task automatic frame(input logic [7:0] b);
		int n;
		n = 0;
		@(negedge pclk);
		while (scl_oe !== 1'b0 && n < 400) begin
			@(negedge pclk);
			n++;
		end
		@(posedge pclk);
		rx_frame_done <= 1'b1;
		rx_shift_byte <= b;
		@(posedge pclk);
		rx_frame_done <= 1'b0;
		rx_shift_byte <= ~b; // Stale byte is not held
	endtask
endmodule
`default_nettype wire

// File: test/iak_ctrl_bench.sv
// Self-checking bench for the acknowledge and handshake block
`timescale 1ns/1ns
`default_nettype none
module iak_ctrl_bench import iak_pkg::*;;
	logic        pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, irq;
	logic        sda_in, tx_ack_slot, rx_frame_done, ack_drive_level, scl_oe, scl_out;
	logic        receive_data_pending, rate_tick, transmit_select, ack_check_enable;
	logic        tx_data_written;
	logic [3:0]  pstrb;
	logic [7:0]  paddr, rx_shift_byte, tx_data;
	logic [31:0] pwdata, prdata;
	int          miscompares, check_count;
	iak_ctrl dut_u (
		.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sda_in(sda_in), .tx_ack_slot(tx_ack_slot),
		.rx_frame_done(rx_frame_done), .rx_shift_byte(rx_shift_byte),
		.ack_drive_level(ack_drive_level), .scl_out(scl_out), .scl_oe(scl_oe),
		.transmit_select(transmit_select), .ack_check_enable(ack_check_enable),
		.receive_data_pending(receive_data_pending), .tx_data(tx_data),
		.tx_data_written(tx_data_written), .rate_tick(rate_tick), .irq(irq)
	);
	iak_far_model far_u (
		.pclk(pclk), .scl_oe(scl_oe), .sda_in(sda_in), .tx_ack_slot(tx_ack_slot),
		.rx_frame_done(rx_frame_done), .rx_shift_byte(rx_shift_byte)
	);
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// ==========================================
	// Tasks
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic settle();
		repeat (2) @(negedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Ready, data and error are taken at the edge that sees ready high
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			end_of_test();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h00000000, r, e);
		chk(r, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask
	// Third period only: the first after a change may be partial
	task automatic period(input int x);
		int c;
		for (int k = 0; k < 3; k++) begin
			c = 0;
			do begin
				@(negedge pclk);
				c++;
			end while (rate_tick !== 1'b1 && c < 300);
		end
		chk(c, x);
	endtask
	// ==========================================
	// Sequence
	initial begin
		presetn = 1'b0;
		pce = 1'b1;
		{psel, penable, pwrite} = 3'h0;
		pstrb = 4'hF;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		miscompares = 0;
		check_count = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(IAK_OFS_SICTL, 32'h0, 1'b0);
		rd(IAK_OFS_STATUS, 32'h0, 1'b1);
		rd(8'h30, 32'h0, 1'b1);
		wr(IAK_OFS_CONTROL, 32'h11);
		wr(IAK_OFS_SICTL, 32'h38);
		rd(IAK_OFS_SICTL, 32'h38, 1'b0);
		rd(IAK_OFS_CONTROL, 32'h0, 1'b0);
		rd(IAK_OFS_STATUS, 32'h0, 1'b0);
		// Lane 0 off: the write must leave the register alone
		pstrb <= 4'hE;
		wr(IAK_OFS_MODE, 32'h7);
		pstrb <= 4'hF;
		rd(IAK_OFS_MODE, 32'h0, 1'b0);
		wr(IAK_OFS_CONTROL, 32'h11);
		settle();
		chk({30'h0, transmit_select, ack_check_enable}, 32'h3);
		far_u.ack_slot(1'b1);
		rd(IAK_OFS_STATUS, 32'h1, 1'b0);
		far_u.ack_slot(1'b0);
		rd(IAK_OFS_STATUS, 32'h0, 1'b0);
		far_u.ack_slot(1'b1);
		wr(IAK_OFS_CONTROL, 32'h10);
		rd(IAK_OFS_STATUS, 32'h0, 1'b0);
		chk({30'h0, transmit_select, ack_check_enable}, 32'h2);
		far_u.ack_slot(1'b1);
		rd(IAK_OFS_STATUS, 32'h0, 1'b0);
		wr(IAK_OFS_STATUS, 32'h1);
		settle();
		chk({31'h0, ack_drive_level}, 32'h1);
		rd(IAK_OFS_STATUS, 32'h0, 1'b0);
		// Write-back of the value read clobbers the level, so it is set again
		wr(IAK_OFS_STATUS, 32'h0);
		settle();
		chk({31'h0, ack_drive_level}, 32'h0);
		wr(IAK_OFS_STATUS, 32'h1);
		wr(IAK_OFS_CONTROL, 32'h00);
		rd(IAK_OFS_STATUS, 32'h1, 1'b0);
		wr(IAK_OFS_STATUS, 32'h0);
		settle();
		chk({31'h0, ack_drive_level}, 32'h0);
		wr(IAK_OFS_DATA, 32'hC5);
		@(negedge pclk);
		chk({31'h0, tx_data_written}, 32'h1);
		@(negedge pclk);
		chk({23'h0, tx_data_written, tx_data}, 32'hC5);
		far_u.frame(8'hA5);
		settle();
		chk({30'h0, scl_out, scl_oe}, 32'h1);
		rd(IAK_OFS_SICTL, 32'h3A, 1'b0);
		rd(IAK_OFS_DATA, 32'hA5, 1'b0);
		settle();
		chk({30'h0, scl_oe, receive_data_pending}, 32'h0);
		wr(IAK_OFS_SICTL, 32'h30);
		far_u.frame(8'h5A);
		settle();
		chk({31'h0, scl_oe}, 32'h0);
		far_u.frame(8'hC3);
		settle();
		chk({31'h0, scl_oe}, 32'h1);
		rd(IAK_OFS_DATA, 32'h5A, 1'b0);
		settle();
		chk({31'h0, receive_data_pending}, 32'h1);
		rd(IAK_OFS_DATA, 32'hC3, 1'b0);
		wr(IAK_OFS_IRQ_CLR, 32'h7);
		wr(IAK_OFS_IRQ_EN, 32'h0);
		rd(IAK_OFS_IRQ_STAT, 32'h0, 1'b0);
		far_u.frame(8'h11);
		rd(IAK_OFS_IRQ_STAT, 32'h2, 1'b0);
		chk({31'h0, irq}, 32'h0);
		wr(IAK_OFS_IRQ_EN, 32'h2);
		settle();
		chk({31'h0, irq}, 32'h1);
		wr(IAK_OFS_IRQ_CLR, 32'h2);
		settle();
		chk({31'h0, irq}, 32'h0);
		rd(IAK_OFS_IRQ_CLR, 32'h0, 1'b0);
		// Frozen by the clock enable: a frame must leave no trace
		@(posedge pclk);
		pce <= 1'b0;
		far_u.frame(8'h77);
		pce <= 1'b1;
		rd(IAK_OFS_IRQ_STAT, 32'h0, 1'b0);
		chk({30'h0, scl_oe, receive_data_pending}, 32'h1);
		for (int x = 0; x < 2; x++) begin
			for (int c = 0; c < 3; c++) begin
				wr(IAK_OFS_MODE, c);
				wr(IAK_OFS_SICTL, 32'h10 | (x << 5));
				period((IAK_RATE_BASE << c) << x);
			end
		end
		wr(IAK_OFS_STATUS, 32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(IAK_OFS_SICTL, 32'h0, 1'b0);
		chk({31'h0, ack_drive_level}, 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
